// File: design/pdac_defs.vh
// Purpose: constants for the PWM DAC bank
// Assumes: included by its bare name
// Notes:   register addresses are an 8-bit special register space
`ifndef PDAC_DEFS_VH
`define PDAC_DEFS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PDAC_CNT_LAST       8'hFE
`define PDAC_CNT_ZERO       8'h00
`define PDAC_GRP_LAST       4'hF
`define PDAC_GRP_ZERO       4'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PDAC_RST_DUTY       8'h00
`define PDAC_RST_STRETCH    4'h0

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PDAC_A_STATIC_DUTY  8'h00
`define PDAC_A_FS_BASE_0    8'h0E
`define PDAC_A_FS_BASE_1    8'h0F
`define PDAC_A_FS_STR_0     8'h10
`define PDAC_A_FS_STR_1     8'h11
`define PDAC_A_DYN_DUTY     8'h12
`define PDAC_A_FD_BASE      8'h15
`define PDAC_A_FD_STR       8'h16
`define PDAC_A_STATUS       8'h17

// ----------------------------------------------------------------------
// Stretch slot patterns within a group of 16 periods
// ----------------------------------------------------------------------
`define PDAC_SLOT_B0        4'h8
`define PDAC_SLOT_B1_MASK   3'h7
`define PDAC_SLOT_B1        3'h4
`define PDAC_SLOT_B2_MASK   2'h3
`define PDAC_SLOT_B2        2'h2

// ----------------------------------------------------------------------
// Channel layout
// ----------------------------------------------------------------------
`define PDAC_N_STATIC       14
`define PDAC_N_DYN          3
`define PDAC_N_FINE         3
`define PDAC_SHARE_FIRST    10
`define PDAC_N_SHARE        4

`endif

// File: design/pdac_bank.v
// Purpose: bank of PWM DAC outputs, 8-bit and 12-bit (PWM plus stretch)
// Assumes: single clock, inputs synchronous, CPU writes one register
//          per sfr_wr pulse
// Notes:   new values are taken at the end of each 255-cycle period
`timescale 1ns/100ps
`default_nettype none
`include "pdac_defs.vh"

module pdac_bank
#(
    parameter DUTY_W    = 8,
    parameter STRETCH_W = 4
)
(
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst_n,
    // CPU register port
    input  wire [7:0]           sfr_addr,
    input  wire                 sfr_wr,
    input  wire [7:0]           sfr_wdata,
    input  wire                 sfr_rd,
    output reg  [7:0]           sfr_rdata,
    output reg                  sfr_hit,
    // Moire control and frame marker
    input  wire                 moire_enable_first,
    input  wire                 moire_enable_second,
    input  wire                 frame_start,
    // Pin sharing with port bits
    input  wire [3:0]           port_share_sel,
    input  wire [3:0]           port_bit_out,
    // DAC outputs
    output reg  [13:0]          static_out,
    output reg  [1:0]           fine_static_out,
    output reg  [2:0]           dynamic_out,
    output reg                  fine_dynamic_out
);

    localparam N8 = `PDAC_N_STATIC + `PDAC_N_DYN;
    localparam NF = `PDAC_N_FINE;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Address of the i-th 8-bit channel (static first, then dynamic)
    function [7:0] duty_addr;
        input integer i;
        integer       j;
        begin
            // Index within the dynamic group, cut to address width
            j = i - `PDAC_N_STATIC;
            if (i < `PDAC_N_STATIC)
                duty_addr = `PDAC_A_STATIC_DUTY + i[7:0];
            else
                duty_addr = `PDAC_A_DYN_DUTY + j[7:0];
        end
    endfunction

    function [7:0] base_addr;
        input integer i;
        begin
            case (i)
                0:       base_addr = `PDAC_A_FS_BASE_0;
                1:       base_addr = `PDAC_A_FS_BASE_1;
                default: base_addr = `PDAC_A_FD_BASE;
            endcase
        end
    endfunction

    function [7:0] str_addr;
        input integer i;
        begin
            case (i)
                0:       str_addr = `PDAC_A_FS_STR_0;
                1:       str_addr = `PDAC_A_FS_STR_1;
                default: str_addr = `PDAC_A_FD_STR;
            endcase
        end
    endfunction

    // True when period slot n gets one extra high clock
    function stretch_hit;
        input [STRETCH_W-1:0] bits;
        input [3:0]           n;
        begin
            // slot map, set bits OR together
            stretch_hit =
                (bits[0] && (n == `PDAC_SLOT_B0)) ||
                (bits[1] && ((n[2:0] & `PDAC_SLOT_B1_MASK)
                              == `PDAC_SLOT_B1)) ||
                (bits[2] && ((n[1:0] & `PDAC_SLOT_B2_MASK)
                              == `PDAC_SLOT_B2)) ||
                (bits[3] && n[0]);
        end
    endfunction

    // ------------------------------------------------------------------
    // Period and group counters
    // ------------------------------------------------------------------
    reg  [7:0] cnt;
    reg  [3:0] grp;
    wire       period_end = (cnt == `PDAC_CNT_LAST);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= `PDAC_CNT_ZERO;
            grp <= `PDAC_GRP_ZERO;
        end
        else if (period_end)
        begin
            cnt <= `PDAC_CNT_ZERO;
            if (grp == `PDAC_GRP_LAST)
                grp <= `PDAC_GRP_ZERO;
            else
                grp <= grp + 4'h1;
        end
        else
        begin
            cnt <= cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Register file: shadow written by CPU, active used by PWM
    // ------------------------------------------------------------------
    reg [DUTY_W-1:0]    duty_sh   [0:N8-1];
    reg [DUTY_W-1:0]    duty_act  [0:N8-1];
    reg [DUTY_W-1:0]    base_sh   [0:NF-1];
    reg [DUTY_W-1:0]    base_act  [0:NF-1];
    reg [STRETCH_W-1:0] str_sh    [0:NF-1];
    reg [STRETCH_W-1:0] str_act   [0:NF-1];
    integer i;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < N8; i = i + 1)
            begin
                duty_sh[i]  <= `PDAC_RST_DUTY;
                duty_act[i] <= `PDAC_RST_DUTY;
            end
            for (i = 0; i < NF; i = i + 1)
            begin
                base_sh[i]  <= `PDAC_RST_DUTY;
                base_act[i] <= `PDAC_RST_DUTY;
                str_sh[i]   <= `PDAC_RST_STRETCH;
                str_act[i]  <= `PDAC_RST_STRETCH;
            end
        end
        else
        begin
            for (i = 0; i < N8; i = i + 1)
            begin
                if (sfr_wr && (sfr_addr == duty_addr(i)))
                    duty_sh[i] <= sfr_wdata;
            end
            // base or stretch write alone suffices
            for (i = 0; i < NF; i = i + 1)
            begin
                if (sfr_wr && (sfr_addr == base_addr(i)))
                    base_sh[i] <= sfr_wdata;
                if (sfr_wr && (sfr_addr == str_addr(i)))
                    str_sh[i] <= sfr_wdata[STRETCH_W-1:0];
            end
            // take new values only at period end
            // Avoids a runt or stretched pulse mid-period
            if (period_end)
            begin
                for (i = 0; i < N8; i = i + 1)
                begin
                    duty_act[i] <= duty_sh[i];
                end
                for (i = 0; i < NF; i = i + 1)
                begin
                    base_act[i] <= base_sh[i];
                    str_act[i]  <= str_sh[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Moire frame phase
    // ------------------------------------------------------------------
    reg moire_blank;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            moire_blank <= 1'b0;
        else if (frame_start)
            moire_blank <= ~moire_blank;
    end

    // ------------------------------------------------------------------
    // Waveform generation
    // ------------------------------------------------------------------
    reg [N8-1:0] next_pwm8;
    reg [NF-1:0] next_fine;
    reg [13:0]   next_static;
    // Own loop index, so no two processes drive one variable
    integer      k_wave;

    always @*
    begin
        next_pwm8   = {N8{1'b0}};
        next_fine   = {NF{1'b0}};
        next_static = 14'h0000;
        // count tops at 254 so 255 is always high
        for (k_wave = 0; k_wave < N8; k_wave = k_wave + 1)
        begin
            next_pwm8[k_wave] = (cnt < duty_act[k_wave]);
        end
        // base compare plus one stretched clock
        // Nine-bit compare so base 255 cannot wrap
        for (k_wave = 0; k_wave < NF; k_wave = k_wave + 1)
        begin
            if (stretch_hit(str_act[k_wave], grp))
                next_fine[k_wave] = ({1'b0, cnt}
                             < ({1'b0, base_act[k_wave]} + 9'h001));
            else
                next_fine[k_wave] = (cnt < base_act[k_wave]);
        end
        next_static = next_pwm8[`PDAC_N_STATIC-1:0];
        // channels 0 and 1 blanked on alternate frames, each by its own enable
        if (moire_enable_first && moire_blank)
            next_static[0] = 1'b0;
        if (moire_enable_second && moire_blank)
            next_static[1] = 1'b0;
        // shared pins carry port bits when selected
        for (k_wave = 0; k_wave < `PDAC_N_SHARE; k_wave = k_wave + 1)
        begin
            if (port_share_sel[k_wave])
                next_static[`PDAC_SHARE_FIRST + k_wave] =
                    port_bit_out[k_wave];
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Registered so the pins never show compare glitches

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            static_out       <= 14'h0000;
            fine_static_out  <= 2'h0;
            dynamic_out      <= 3'h0;
            fine_dynamic_out <= 1'b0;
        end
        else
        begin
            static_out       <= next_static;
            fine_static_out  <= next_fine[1:0];
            dynamic_out      <= next_pwm8[N8-1:`PDAC_N_STATIC];
            fine_dynamic_out <= next_fine[2];
        end
    end

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    reg [7:0] next_rdata;
    reg       next_hit;
    integer   k_rd;

    // Reads return the last written value, not the active one
    // Software may see a value that is not yet on the pin
    always @*
    begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
        for (k_rd = 0; k_rd < N8; k_rd = k_rd + 1)
        begin
            if (sfr_addr == duty_addr(k_rd))
            begin
                next_rdata = duty_sh[k_rd];
                next_hit   = 1'b1;
            end
        end
        for (k_rd = 0; k_rd < NF; k_rd = k_rd + 1)
        begin
            if (sfr_addr == base_addr(k_rd))
            begin
                next_rdata = base_sh[k_rd];
                next_hit   = 1'b1;
            end
            // Upper stretch bits read as zero
            if (sfr_addr == str_addr(k_rd))
            begin
                next_rdata = {4'h0, str_sh[k_rd]};
                next_hit   = 1'b1;
            end
        end
        if (sfr_addr == `PDAC_A_STATUS)
        begin
            next_rdata = {3'h0, moire_blank, grp};
            next_hit   = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end
        else if (sfr_rd)
        begin
            sfr_rdata <= next_rdata;
            sfr_hit   <= next_hit;
        end
        else
        begin
            sfr_hit   <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: tb/pdac_bank_sva.sv
// Purpose: port-level checks of the PWM DAC bank
// Assumes: sees only the bank's ports
// Notes:   own period counter and blank phase mirror the bank
`timescale 1ns/100ps
`default_nettype none
module pdac_bank_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        sfr_hit,
    // Moire and pin sharing
    input wire logic        moire_enable_first,
    input wire logic        moire_enable_second,
    input wire logic        frame_start,
    input wire logic [3:0]  port_share_sel,
    input wire logic [3:0]  port_bit_out,
    // Outputs
    input wire logic [13:0] static_out,
    input wire logic [1:0]  fine_static_out,
    input wire logic [2:0]  dynamic_out,
    input wire logic        fine_dynamic_out
);
    logic [7:0]  hcnt;
    logic        ph;
    // Pins free of moire and sharing
    wire  [13:0] pw = {static_out[9:2], dynamic_out, fine_static_out,
                       fine_dynamic_out};
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            hcnt <= 8'h00;
            ph   <= 1'b0;
        end
        else
        begin
            hcnt <= (hcnt == 8'hFE) ? 8'h00 : hcnt + 8'h01;
            ph   <= ph ^ frame_start;
        end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd_hit;
        sfr_rd && sfr_addr <= 8'h17 |=> sfr_hit;
    endproperty
    a_rd_hit: assert property (p_rd_hit) else $error("no hit");
    property p_rd_miss;
        sfr_rd && sfr_addr > 8'h17 |=> !sfr_hit && sfr_rdata == 8'h00;
    endproperty
    a_rd_miss: assert property (p_rd_miss) else $error("bad miss");
    property p_hit_src;
        sfr_hit |-> $past(sfr_rd);
    endproperty
    a_hit_src: assert property (p_hit_src) else $error("stray hit");
    property p_rst_low;
        !$past(rst_n) |-> {static_out[9:0], pw} == 24'h000000;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("not low");
    property p_moire0;
        moire_enable_first && ph |=> !static_out[0];
    endproperty
    a_moire0: assert property (p_moire0) else $error("ch0 on");
    property p_moire1;
        moire_enable_second && ph |=> !static_out[1];
    endproperty
    a_moire1: assert property (p_moire1) else $error("ch1 on");
    property p_rise;
        (pw & ~$past(pw)) != 14'h0000 |-> hcnt == 8'h01;
    endproperty
    a_rise: assert property (p_rise) else $error("rise off");
    property p_share;
        port_share_sel == 4'hF && $stable(port_share_sel)
            && $stable(port_bit_out) |-> static_out[13:10] == port_bit_out;
    endproperty
    a_share: assert property (p_share) else $error("share");
endmodule
bind pdac_bank pdac_bank_sva u_sva (
    .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .moire_enable_first(moire_enable_first),
    .moire_enable_second(moire_enable_second), .frame_start(frame_start),
    .port_share_sel(port_share_sel), .port_bit_out(port_bit_out),
    .static_out(static_out), .fine_static_out(fine_static_out),
    .dynamic_out(dynamic_out), .fine_dynamic_out(fine_dynamic_out)
);
`default_nettype wire

// File: tb/pdac_rc_model.sv
// Purpose: integrating far-side load on one DAC pin
// Assumes: clr held high for at least one clock
// Notes:   counts high clocks; a true RC needs real time
`timescale 1ns/100ps
`default_nettype none
module pdac_rc_model (
    // Clock
    input  wire logic        clk,
    // Pin and control
    input  wire logic        pin,
    input  wire logic        clr,
    // Integrated charge
    output var  logic [11:0] acc
);
    always @(posedge clk)
        if (clr)
            acc <= 12'h000;
        else if (pin)
            acc <= acc + 12'h001;
endmodule
`default_nettype wire

// File: tb/tb_pwm_static_dynamic_dac_bank.sv
// Purpose: self-checking bench for the PWM DAC bank
// Assumes: inputs change on the falling clock edge
// Notes:   duty is judged by the integrating far-side model
`timescale 1ns/100ps
`default_nettype none
module tb_pwm_static_dynamic_dac_bank;
    logic        clk, rst_n, sfr_wr, sfr_rd, sfr_hit, frame_start, clr;
    logic        moire_enable_first, moire_enable_second, fine_dynamic_out;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [3:0]  port_share_sel, port_bit_out;
    logic [13:0] static_out;
    logic [1:0]  fine_static_out;
    logic [2:0]  dynamic_out;
    logic [4:0]  sel;
    logic [11:0] acc;
    int          error_cnt, n_checks;
    wire  [19:0] outs = {fine_dynamic_out, dynamic_out, fine_static_out,
                         static_out};
    pdac_bank dut_u (
        .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .moire_enable_first(moire_enable_first),
        .moire_enable_second(moire_enable_second),
        .frame_start(frame_start), .port_share_sel(port_share_sel),
        .port_bit_out(port_bit_out), .static_out(static_out),
        .fine_static_out(fine_static_out), .dynamic_out(dynamic_out),
        .fine_dynamic_out(fine_dynamic_out)
    );
    pdac_rc_model rc_u (.clk(clk), .pin(outs[sel]), .clr(clr), .acc(acc));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, e, input logic h);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk({3'h0, sfr_hit, sfr_rdata}, {3'h0, h, e});
    endtask
    // Integrate one pin over n clocks
    task automatic meas(input logic [4:0] s, input int n, input logic [11:0] e);
        sel = s;
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (n) @(negedge clk);
        chk(acc, e);
    endtask
    task automatic t_regs;
        logic [7:0] m;
        for (int a = 0; a < 23; a++)
        begin
            m = (a == 16 || a == 17 || a == 22) ? 8'h0F : 8'hFF;
            rd_chk(a[7:0], 8'h00, 1'b1);
            wr(a[7:0], 8'hA5 ^ a[7:0]);
            rd_chk(a[7:0], (8'hA5 ^ a[7:0]) & m, 1'b1);
            wr(a[7:0], 8'h00);
        end
        wr(8'h30, 8'h77);
        rd_chk(8'h30, 8'h00, 1'b0);
        $display("regs done");
    endtask
    task automatic t_duty;
        logic [7:0] tbl [5] = '{8'h00, 8'h01, 8'h80, 8'hFE, 8'hFF};
        for (int i = 0; i < 20; i++)
        begin
            wr(i[7:0] + ((i > 15) ? 8'h02 : 8'h00), tbl[i % 5]);
            repeat (510) @(negedge clk);
            meas(i[4:0], 255, {4'h0, tbl[i % 5]});
        end
        $display("duty done");
    endtask
    task automatic t_fine;
        logic [7:0] b;
        logic [3:0] s;
        logic [4:0] ch;
        for (int i = 0; i < 6; i++)
        begin
            ch = (i < 4) ? 5'h0E : (i == 4) ? 5'h0F : 5'h13;
            s = (i < 4) ? 4'h1 << i : 4'hF;
            b = (i == 5) ? 8'hFF : 8'h40;
            wr({3'h0, ch} + ((ch > 5'h0F) ? 8'h02 : 8'h00), b);
            wr({3'h0, ch} + ((ch == 5'h13) ? 8'h03 : 8'h02), {4'h0, s});
            repeat (510) @(negedge clk);
            meas(ch, 4080, (b == 8'hFF) ? 12'hFF0 : {b, 4'h0} + s);
        end
        $display("fine done");
    endtask
    task automatic t_moire;
        wr(8'h00, 8'hFF);
        wr(8'h01, 8'hFF);
        repeat (510) @(negedge clk);
        for (int p = 1; p < 7; p++)
        begin
            moire_enable_first = (p < 5);
            moire_enable_second = (p < 5);
            frame_start = 1'b1;
            @(negedge clk);
            frame_start = 1'b0;
            repeat (3) @(negedge clk);
            meas(5'h00, 255, (p[0] && p < 5) ? 12'h000 : 12'h0FF);
            meas(5'h01, 255, (p[0] && p < 5) ? 12'h000 : 12'h0FF);
        end
        $display("moire done");
    endtask
    task automatic t_share;
        port_bit_out = 4'hA;
        port_share_sel = 4'hF;
        repeat (3) @(negedge clk);
        chk({8'h00, static_out[13:10]}, 12'h00A);
        port_bit_out = 4'h5;
        repeat (3) @(negedge clk);
        chk({8'h00, static_out[13:10]}, 12'h005);
        port_share_sel = 4'h0;
        repeat (600) @(negedge clk);
        chk({11'h000, static_out[10]}, 12'h000);
        $display("share done");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        {rst_n, sfr_wr, sfr_rd, frame_start, clr} = 5'h00;
        {moire_enable_first, moire_enable_second} = 2'h0;
        {sfr_addr, sfr_wdata, port_share_sel, port_bit_out} = 24'h000000;
        sel = 5'h00;
        error_cnt = 0;
        n_checks = 0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_regs;
        t_duty;
        t_fine;
        t_moire;
        t_share;
        complete_run;
    end
    // Run needs about 50k clocks
    initial
    begin
        #(90000 * 8);
        error_cnt++;
        complete_run;
    end
endmodule
`default_nettype wire
